/* File: pkg/ext_req_pkg.sv */
// Shared constants and types for the external request flag block
package ext_req_pkg;
   localparam int          NUM_REQ     = 4;
   localparam int          ADDR_W      = 12;
   localparam int          DATA_W      = 32;
   localparam int          SYNC_STAGES = 3;
   localparam int          SENSE_W     = 2;
   localparam int          FLAG_LSB    = 0;
   localparam int          LEVEL_LSB   = 8;
   localparam int          SENSE_LSB   = 0;
   localparam int          CTRL_BITS   = NUM_REQ * SENSE_W;
   localparam logic [11:0] STAT_OFFS   = 12'h000;
   localparam logic [11:0] CTRL_OFFS   = 12'h004;
   localparam logic [3:0]  FLAG_RST    = 4'h0;
   localparam logic [3:0]  ARM_RST     = 4'h0;
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic        LEVEL_RST   = 1'h1;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      SENSE_LEVEL = 2'b00,
      SENSE_FALL  = 2'b01,
      SENSE_RISE  = 2'b10,
      SENSE_BOTH  = 2'b11
   } sense_t;
endpackage : ext_req_pkg

/* File: pkg/reg_if.sv */
// Register access strobes between the bus slave and the flag logic
`timescale 1ns/100ps
interface reg_if;
   logic        wr_pulse;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        rd_pulse;
   logic [11:0] rd_addr;
   logic [31:0] rd_data;
   modport bus (output wr_pulse, wr_addr, wr_data, wr_strb, rd_pulse, rd_addr,
                input rd_data);
   modport regs (input wr_pulse, wr_addr, wr_data, wr_strb, rd_pulse, rd_addr,
                 output rd_data);
endinterface : reg_if

/* File: hw/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module pin_sync #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] lvl_ff;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!resetn) begin
               s1_ff[i]  <= ext_req_pkg::LEVEL_RST;
               s2_ff[i]  <= ext_req_pkg::LEVEL_RST;
               s3_ff[i]  <= ext_req_pkg::LEVEL_RST;
               lvl_ff[i] <= ext_req_pkg::LEVEL_RST;
            end else if (ce) begin
               s1_ff[i] <= pin_in[i];
               s2_ff[i] <= s1_ff[i];
               s3_ff[i] <= s2_ff[i];
               // One-cycle glitches never reach the flags
               if (s2_ff[i] == s3_ff[i]) begin
                  lvl_ff[i] <= s3_ff[i];
               end
            end
         end
         assign rise[i] = ce & s2_ff[i] & s3_ff[i] & ~lvl_ff[i];
         assign fall[i] = ce & ~s2_ff[i] & ~s3_ff[i] & lvl_ff[i];

         property p_agree;
            @(posedge clk) disable iff (!resetn)
            (ce && s2_ff[i] == s3_ff[i]) |=> (lvl_ff[i] == $past(s3_ff[i]));
         endproperty
         a_agree: assert property (p_agree) else $error("level missed agreement");
      end
   endgenerate

   assign level = lvl_ff;
endmodule : pin_sync

/* File: hw/axil_slave.sv */
// AXI4-Lite slave turning bus transfers into register strobes
`timescale 1ns/100ps
module axil_slave (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic [11:0] s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [11:0] s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   reg_if.bus               rb
);
   logic        aw_got_ff;
   logic        w_got_ff;
   logic [11:0] waddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        wr_fire;
   logic        ar_hs;

   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a[11:2] == ext_req_pkg::STAT_OFFS[11:2]) ||
                (a[11:2] == ext_req_pkg::CTRL_OFFS[11:2]);
   endfunction : addr_ok

   // Ready and valid are gated by ce so no beat is taken while frozen
   assign s_awready = ce & ~aw_got_ff & ~bvalid_ff;
   assign s_wready  = ce & ~w_got_ff & ~bvalid_ff;
   assign s_arready = ce & ~rvalid_ff;
   assign s_bvalid  = ce & bvalid_ff;
   assign s_rvalid  = ce & rvalid_ff;
   assign s_bresp   = bresp_ff;
   assign s_rdata   = rdata_ff;
   assign s_rresp   = rresp_ff;
   assign wr_fire   = ce & aw_got_ff & w_got_ff & ~bvalid_ff;
   assign ar_hs     = s_arvalid & s_arready;
   assign rb.wr_pulse = wr_fire & addr_ok(waddr_ff);
   assign rb.wr_addr  = waddr_ff;
   assign rb.wr_data  = wdata_ff;
   assign rb.wr_strb  = wstrb_ff;
   assign rb.rd_pulse = ar_hs & addr_ok(s_araddr);
   assign rb.rd_addr  = s_araddr;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_got_ff <= 1'b0;
         waddr_ff  <= 12'h000;
      end else if (s_awvalid && s_awready) begin
         aw_got_ff <= 1'b1;
         waddr_ff  <= s_awaddr;
      end else if (wr_fire) begin
         aw_got_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         w_got_ff <= 1'b0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end else if (s_wvalid && s_wready) begin
         w_got_ff <= 1'b1;
         wdata_ff <= s_wdata;
         wstrb_ff <= s_wstrb;
      end else if (wr_fire) begin
         w_got_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= ext_req_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= addr_ok(waddr_ff) ? ext_req_pkg::RESP_OKAY : ext_req_pkg::RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0000_0000;
         rresp_ff  <= ext_req_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= addr_ok(s_araddr) ? rb.rd_data : 32'h0000_0000;
         rresp_ff  <= addr_ok(s_araddr) ? ext_req_pkg::RESP_OKAY : ext_req_pkg::RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
endmodule : axil_slave

/* File: hw/ext_int_request_flags.sv */
// Request flags for four external interrupt inputs behind AXI4-Lite
// Contract
// - One read/write flag per input at bits 3..0, reset to 0.
// - Level mode: flag set while its pin is low.
// - Level mode: flag cleared by pin high, no software needed.
// - Edge mode: selected edge sets the flag, held until cleared.
// - Edge mode: writing 0 after reading 1 clears the flag.
// - Edge mode: processor acceptance of the interrupt clears the flag.
// - Read-only pin level bits, input 3 at bit 11, 1 means high.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module ext_int_request_flags #(
   parameter int N = ext_req_pkg::NUM_REQ
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic        ext_req0_pin,
   input  wire logic        ext_req1_pin,
   input  wire logic        ext_req2_pin,
   input  wire logic        ext_req3_pin,
   input  wire logic [3:0]  irq_accept,
   output logic             ext_req0_flag,
   output logic             ext_req1_flag,
   output logic             ext_req2_flag,
   output logic             ext_req3_flag,
   output logic             ext_req3_pin_level,
   input  wire logic [11:0] s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [11:0] s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready
);
   reg_if rb ();

   logic [3:0] pins;
   logic [3:0] level;
   logic [3:0] rise;
   logic [3:0] fall;
   logic [3:0] flag_ff;
   logic [3:0] arm_ff;
   logic [7:0] ctrl_ff;
   logic [3:0] edge_hit;
   logic [3:0] is_level;
   logic [3:0] sw_clr;
   logic       stat_wr;
   logic       stat_rd;
   logic       ctrl_wr;
   logic       stat_rd_sel;

   assign pins = {ext_req3_pin, ext_req2_pin, ext_req1_pin, ext_req0_pin};

   pin_sync #(
      .W (N)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .pin_in (pins),
      .level  (level),
      .rise   (rise),
      .fall   (fall)
   );

   axil_slave u_bus (
      .clk       (clk),
      .resetn    (resetn),
      .ce        (ce),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .rb        (rb.bus)
   );

   // Register decode, low byte lane carries every writable field
   assign stat_wr = rb.wr_pulse & rb.wr_strb[0] &
                    (rb.wr_addr[11:2] == ext_req_pkg::STAT_OFFS[11:2]);
   assign ctrl_wr = rb.wr_pulse & rb.wr_strb[0] &
                    (rb.wr_addr[11:2] == ext_req_pkg::CTRL_OFFS[11:2]);
   assign stat_rd_sel = (rb.rd_addr[11:2] == ext_req_pkg::STAT_OFFS[11:2]);
   assign stat_rd = rb.rd_pulse & stat_rd_sel;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl_ff <= ext_req_pkg::CTRL_RST;
      end else if (ce && ctrl_wr) begin
         ctrl_ff <= rb.wr_data[7:0];
      end
   end

   // Read mux; pin levels are live, reserved bits read zero
   always_comb begin
      rb.rd_data = 32'h0000_0000;
      if (stat_rd_sel) begin
         rb.rd_data[ext_req_pkg::FLAG_LSB +: 4]  = flag_ff;
         rb.rd_data[ext_req_pkg::LEVEL_LSB +: 4] = level;
      end else begin
         rb.rd_data[ext_req_pkg::SENSE_LSB +: 8] = ctrl_ff;
      end
   end

   genvar n;
   generate
      for (n = 0; n < N; n++) begin : g_req
         ext_req_pkg::sense_t sense;

         assign sense = ext_req_pkg::sense_t'(ctrl_ff[2*n +: 2]);

         always_comb begin
            case (sense)
               ext_req_pkg::SENSE_FALL: edge_hit[n] = fall[n];
               ext_req_pkg::SENSE_RISE: edge_hit[n] = rise[n];
               ext_req_pkg::SENSE_BOTH: edge_hit[n] = rise[n] | fall[n];
               default:                 edge_hit[n] = 1'b0;
            endcase
         end

         assign is_level[n] = (sense == ext_req_pkg::SENSE_LEVEL);
         // Needs a prior read of 1; writes of 1 are dropped
         assign sw_clr[n] = stat_wr & ~rb.wr_data[n] & arm_ff[n];

         // Edge beats any clear in the same cycle so no request is lost
         always_ff @(posedge clk) begin
            if (!resetn) begin
               flag_ff[n] <= ext_req_pkg::FLAG_RST[n];
            end else if (ce) begin
               if (is_level[n]) begin
                  flag_ff[n] <= ~level[n];
               end else if (edge_hit[n]) begin
                  flag_ff[n] <= 1'b1;
               end else if (sw_clr[n] || irq_accept[n]) begin
                  flag_ff[n] <= 1'b0;
               end
            end
         end

         // Arm only records a read that really saw the flag at 1
         always_ff @(posedge clk) begin
            if (!resetn) begin
               arm_ff[n] <= ext_req_pkg::ARM_RST[n];
            end else if (ce) begin
               if (sw_clr[n] || irq_accept[n] || !flag_ff[n] || is_level[n]) begin
                  arm_ff[n] <= 1'b0;
               end else if (stat_rd) begin
                  arm_ff[n] <= 1'b1;
               end
            end
         end

         property p_lvl_set;
            @(posedge clk) disable iff (!resetn)
            (ce && is_level[n] && !level[n]) |=> flag_ff[n];
         endproperty
         a_lvl_set: assert property (p_lvl_set)
            else $error("level low did not set flag");

         property p_lvl_clr;
            @(posedge clk) disable iff (!resetn)
            (ce && is_level[n] && level[n]) |=> !flag_ff[n];
         endproperty
         a_lvl_clr: assert property (p_lvl_clr)
            else $error("level high did not clear flag");

         property p_edge_set;
            @(posedge clk) disable iff (!resetn)
            (ce && !is_level[n] && edge_hit[n]) |=> flag_ff[n];
         endproperty
         a_edge_set: assert property (p_edge_set)
            else $error("edge did not set flag");

         property p_edge_hold;
            @(posedge clk) disable iff (!resetn)
            (flag_ff[n] && !is_level[n] && !sw_clr[n] && !irq_accept[n])
               |=> flag_ff[n] || $past(ce) && $past(is_level[n]);
         endproperty
         a_edge_hold: assert property (p_edge_hold)
            else $error("edge flag dropped without clear");

         // Arm stands for the earlier read of 1, whatever the gap
         property p_sw_clr;
            @(posedge clk) disable iff (!resetn)
            (ce && !is_level[n] && arm_ff[n] && stat_wr && !rb.wr_data[n] && !edge_hit[n])
               |=> !flag_ff[n];
         endproperty
         a_sw_clr: assert property (p_sw_clr)
            else $error("write 0 after read 1 did not clear");

         property p_accept;
            @(posedge clk) disable iff (!resetn)
            (ce && !is_level[n] && irq_accept[n] && !edge_hit[n]) |=> !flag_ff[n];
         endproperty
         a_accept: assert property (p_accept)
            else $error("acceptance did not clear flag");

         property p_no_sw_set;
            @(posedge clk) disable iff (!resetn)
            (ce && !is_level[n] && !flag_ff[n] && !edge_hit[n]) |=> !flag_ff[n];
         endproperty
         a_no_sw_set: assert property (p_no_sw_set)
            else $error("flag set without an edge");

         property p_unarmed;
            @(posedge clk) disable iff (!resetn)
            (ce && !is_level[n] && !arm_ff[n] && flag_ff[n] && !edge_hit[n]
               && !irq_accept[n]) |=> flag_ff[n];
         endproperty
         a_unarmed: assert property (p_unarmed)
            else $error("unarmed write cleared flag");

         property p_arm_set;
            @(posedge clk) disable iff (!resetn)
            (ce && stat_rd && flag_ff[n] && !is_level[n] && !irq_accept[n] && !sw_clr[n])
               |=> arm_ff[n];
         endproperty
         a_arm_set: assert property (p_arm_set)
            else $error("read of 1 did not arm clear");

         property p_arm_by_read;
            @(posedge clk) disable iff (!resetn)
            (ce && !arm_ff[n] && !stat_rd) |=> !arm_ff[n];
         endproperty
         a_arm_by_read: assert property (p_arm_by_read)
            else $error("clear armed without a read");

         property p_wr_one;
            @(posedge clk) disable iff (!resetn)
            (ce && !is_level[n] && flag_ff[n] && stat_wr && rb.wr_data[n] && !irq_accept[n])
               |=> flag_ff[n];
         endproperty
         a_wr_one: assert property (p_wr_one)
            else $error("write of 1 changed flag");

         // Frozen state must not drift while the enable is low
         property p_freeze;
            @(posedge clk) disable iff (!resetn)
            !ce |=> (flag_ff[n] == $past(flag_ff[n]) && arm_ff[n] == $past(arm_ff[n]));
         endproperty
         a_freeze: assert property (p_freeze)
            else $error("flag moved while frozen");
      end
   endgenerate

   property p_reset_val;
      @(posedge clk) disable iff (!resetn)
      $past(!resetn) |-> (flag_ff == 4'h0 && arm_ff == 4'h0);
   endproperty
   a_reset_val: assert property (p_reset_val)
      else $error("flags not zero after reset");

   property p_pin_bits;
      @(posedge clk) disable iff (!resetn)
      (rb.rd_pulse && stat_rd_sel) |=> (s_rdata[11:8] == $past(level));
   endproperty
   a_pin_bits: assert property (p_pin_bits)
      else $error("pin level bits read wrong");

   property p_rsvd_zero;
      @(posedge clk) disable iff (!resetn)
      (rb.rd_pulse && stat_rd_sel) |=> (s_rdata[31:12] == 20'h00000 && s_rdata[7:4] == 4'h0);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved status bits not zero");

   property p_ctrl_freeze;
      @(posedge clk) disable iff (!resetn)
      !ce |=> $stable(ctrl_ff);
   endproperty
   a_ctrl_freeze: assert property (p_ctrl_freeze)
      else $error("mode bits moved while frozen");

   assign ext_req0_flag      = flag_ff[0];
   assign ext_req1_flag      = flag_ff[1];
   assign ext_req2_flag      = flag_ff[2];
   assign ext_req3_flag      = flag_ff[3];
   assign ext_req3_pin_level = level[3];
endmodule : ext_int_request_flags

/* File: tb/pin_partner.sv */
// Model of the external request pins and the processor's acceptance
`timescale 1ns/100ps
module pin_partner (
   input  wire logic       clk,
   input  wire logic [3:0] pin_cmd,
   input  wire logic [3:0] accept_cmd,
   input  wire logic [3:0] flags,
   output logic      [3:0] pins,
   output logic      [3:0] irq_accept
);
   initial begin
      pins = 4'hF;
      irq_accept = 4'h0;
   end
   // Pins move off the clock grid, as real async inputs do
   always @(pin_cmd) begin
      pins <= #7 pin_cmd;
   end
   // Processor only accepts a request that is pending, one cycle each
   always @(posedge clk) begin
      irq_accept <= accept_cmd & flags;
   end
endmodule : pin_partner

/* File: tb/tb_top.sv */
// Self-checking bench for the external request flag block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
   logic        clk, resetn, ce;
   logic [11:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0]  s_wstrb, pins, irq_accept, pin_cmd, accept_cmd, flags;
   logic [1:0]  s_bresp, s_rresp, r;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic        s_arvalid, s_arready, s_rvalid, s_rready, pin3_level;
   logic [4:0]  obs;
   int          n_mismatch, n_compared;
   assign obs = {pin3_level, flags};
   ext_int_request_flags dut_u (.clk(clk), .resetn(resetn), .ce(ce),
      .ext_req0_pin(pins[0]), .ext_req1_pin(pins[1]), .ext_req2_pin(pins[2]),
      .ext_req3_pin(pins[3]), .irq_accept(irq_accept),
      .ext_req0_flag(flags[0]), .ext_req1_flag(flags[1]), .ext_req2_flag(flags[2]),
      .ext_req3_flag(flags[3]), .ext_req3_pin_level(pin3_level),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
   pin_partner partner_u (.clk(clk), .pin_cmd(pin_cmd), .accept_cmd(accept_cmd),
      .flags(flags), .pins(pins), .irq_accept(irq_accept));

   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic give_up();
      n_mismatch++;
      report_and_stop();
   endtask : give_up
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask : cycles
   // Bounded wait on a flag or the pin level bit
   task automatic wait_obs(input int i, input logic v);
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (obs[i] === v)
            break;
      end
      if (n == 20)
         give_up();
   endtask : wait_obs
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                            output logic [1:0] resp);
      int n;
      @(posedge clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= 4'hF;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_awready === 1'h1)
            s_awvalid <= 1'h0;
         if (s_wready === 1'h1)
            s_wvalid <= 1'h0;
         if (s_bvalid === 1'h1)
            break;
      end
      if (n == 50)
         give_up();
      resp = s_bresp;
      s_bready <= 1'h0;
   endtask : axi_write
   task automatic chk_read(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
      int n;
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_arready === 1'h1)
            s_arvalid <= 1'h0;
         if (s_rvalid === 1'h1)
            break;
      end
      if (n == 50)
         give_up();
      `CHK("read data", d, s_rdata)
      `CHK("read resp", rs, s_rresp)
      s_rready <= 1'h0;
   endtask : chk_read

   task automatic t_reset();
      chk_read(ext_req_pkg::STAT_OFFS, 32'h00000F00, ext_req_pkg::RESP_OKAY);
      chk_read(ext_req_pkg::CTRL_OFFS, 32'h00000000, ext_req_pkg::RESP_OKAY);
      `CHK("flags", 4'h0, flags)
      // Input 0 level, 1 falling, 2 rising, 3 both edges
      axi_write(ext_req_pkg::CTRL_OFFS, 32'h000000E4, r);
      `CHK("ctrl bresp", ext_req_pkg::RESP_OKAY, r)
      chk_read(ext_req_pkg::CTRL_OFFS, 32'h000000E4, ext_req_pkg::RESP_OKAY);
      $display("test reset and modes done");
   endtask : t_reset
   task automatic t_level();
      pin_cmd <= 4'hE;
      wait_obs(0, 1'h1);
      `CHK("flags", 4'h1, flags)
      chk_read(ext_req_pkg::STAT_OFFS, 32'h00000E01, ext_req_pkg::RESP_OKAY);
      pin_cmd <= 4'hF;
      wait_obs(0, 1'h0);
      `CHK("flags", 4'h0, flags)
      $display("test level done");
   endtask : t_level
   task automatic t_edge_sw();
      pin_cmd <= 4'h5;
      wait_obs(4, 1'h0);
      `CHK("pin3 level", 1'h0, pin3_level)
      wait_obs(1, 1'h1);
      pin_cmd <= 4'hF;
      cycles(10);
      `CHK("flags", 4'hA, flags)
      // Clear attempt without the read first must be ignored
      axi_write(ext_req_pkg::STAT_OFFS, 32'h00000000, r);
      cycles(2);
      `CHK("flags", 4'hA, flags)
      chk_read(ext_req_pkg::STAT_OFFS, 32'h00000F0A, ext_req_pkg::RESP_OKAY);
      axi_write(ext_req_pkg::STAT_OFFS, 32'h0000000D, r);
      cycles(2);
      `CHK("flags", 4'h8, flags)
      $display("test edge clear by software done");
   endtask : t_edge_sw
   task automatic t_edge_accept();
      pin_cmd <= 4'hB;
      cycles(10);
      `CHK("flags", 4'h8, flags)
      pin_cmd <= 4'hF;
      wait_obs(2, 1'h1);
      `CHK("flags", 4'hC, flags)
      accept_cmd <= 4'hC;
      @(posedge clk);
      accept_cmd <= 4'h0;
      cycles(3);
      `CHK("flags", 4'h0, flags)
      $display("test edge clear by acceptance done");
   endtask : t_edge_accept
   task automatic t_writes();
      axi_write(ext_req_pkg::STAT_OFFS, 32'h0000000F, r);
      cycles(2);
      `CHK("flags", 4'h0, flags)
      axi_write(12'h008, 32'h000000FF, r);
      `CHK("unmapped bresp", ext_req_pkg::RESP_SLVERR, r)
      chk_read(12'h008, 32'h00000000, ext_req_pkg::RESP_SLVERR);
      chk_read(ext_req_pkg::CTRL_OFFS, 32'h000000E4, ext_req_pkg::RESP_OKAY);
      $display("test writes and unmapped done");
   endtask : t_writes
   task automatic t_ce_reset();
      // Pin 0 drops while frozen: nothing may move until the enable returns
      ce <= 1'h0;
      pin_cmd <= 4'hE;
      cycles(10);
      `CHK("frozen flags", 4'h0, flags)
      ce <= 1'h1;
      wait_obs(0, 1'h1);
      `CHK("flags", 4'h1, flags)
      pin_cmd <= 4'h7;
      wait_obs(3, 1'h1);
      pin_cmd <= 4'hF;
      cycles(10);
      `CHK("flags", 4'h8, flags)
      resetn <= 1'h0;
      cycles(4);
      resetn <= 1'h1;
      `CHK("flags after reset", 4'h0, flags)
      chk_read(ext_req_pkg::CTRL_OFFS, 32'h00000000, ext_req_pkg::RESP_OKAY);
      chk_read(ext_req_pkg::STAT_OFFS, 32'h00000F00, ext_req_pkg::RESP_OKAY);
      $display("test clock enable and reset done");
   endtask : t_ce_reset

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   initial begin
      resetn = 1'h0;
      ce = 1'h1;
      {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      pin_cmd = 4'hF;
      accept_cmd = 4'h0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'h1;
      t_reset();
      t_level();
      t_edge_sw();
      t_edge_accept();
      t_writes();
      t_ce_reset();
      report_and_stop();
   end
endmodule : tb_top
